//--- hw/sarps_pkg.sv
// What this block does
// RULE_01: strobe fall with select low leaves power-down and starts acquisition.
// RULE_02: next strobe fall after acquisition start begins a conversion.
// RULE_03: select at conversion start: high powers reference down afterwards, low keeps it.
// RULE_04: done line goes low once a result is ready to read.
// RULE_05: strobe fall with select high drives a valid result onto the bus.
// RULE_06: result is sixteen bits over eight lines, msb top of upper byte.
// RULE_07: byte select high shows the upper byte, low the lower byte.
// RULE_08: host reads both bytes and waits before starting a new acquisition.
// RULE_09: bus is released unless a read runs, freed when the strobe rises.
package sarps_pkg;

    // -----------------------------------------------------------------
    // widths and timing
    // -----------------------------------------------------------------
    localparam int RESULT_W = 16;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_CONV_NS = 4700;
    // longest time, so round down
    localparam int CONV_CYCLES = T_CONV_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // -----------------------------------------------------------------
    // sequencer states
    // -----------------------------------------------------------------
    typedef enum logic [4:0] {
        S_SHUTDOWN = 5'h01,
        S_ACQUIRE = 5'h02,
        S_CONVERT = 5'h04,
        S_STORE = 5'h08,
        S_READ = 5'h10
    } sarps_state_t;

endpackage : sarps_pkg

//--- hw/sarps_fifo.sv
`timescale 1ns/10ps
module sarps_fifo
    import sarps_pkg::*;
#(
    parameter int WIDTH = RESULT_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] count_q, count_d;
    logic push, pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == LAST_PTR) ? '0 : p + AW'(1);
    endfunction : bump

    assign in_ready = (count_q != FULL_COUNT);
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_d = push ? bump(wr_q) : wr_q;
        rd_d = pop ? bump(rd_q) : rd_q;
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + (AW + 1)'(1);
        end else if (pop && !push) begin
            count_d = count_q - (AW + 1)'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            count_q <= count_d;
        end
    end

    // storage needs no reset; empty flag guards it
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

endmodule : sarps_fifo

//--- hw/sarps_sequencer.sv
`timescale 1ns/10ps
module sarps_sequencer
    import sarps_pkg::*;
#(
    parameter int CONV_COUNT = CONV_CYCLES,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic conversion_strobe_n,
    input wire logic read_convert_select,
    input wire logic high_byte_select,
    input wire logic [RESULT_W-1:0] adc_result,
    output logic core_power_on,
    output logic ref_power_on,
    output logic track_enable,
    output logic conversion_done_n,
    output logic [BYTE_W-1:0] data_out,
    output logic data_oe
);
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_COUNT - 1);

    // -----------------------------------------------------------------
    // strobe edges
    // -----------------------------------------------------------------
    logic strobe_q, strobe_d;
    logic strobe_fall, strobe_rise;

    // reset value matches the idle level of the pin, so the first
    // sample after reset cannot fake a rise
    always_comb begin
        strobe_d = conversion_strobe_n;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            strobe_q <= 1'b1;
        end else begin
            strobe_q <= strobe_d;
        end
    end

    assign strobe_fall = strobe_q && !conversion_strobe_n;
    assign strobe_rise = !strobe_q && conversion_strobe_n;

    // -----------------------------------------------------------------
    // result buffer
    // -----------------------------------------------------------------
    logic fifo_in_valid, fifo_in_ready;
    logic fifo_out_valid, fifo_out_ready;
    logic [RESULT_W-1:0] fifo_out_data;
    logic [RESULT_W-1:0] result_q, result_d;

    sarps_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(result_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    sarps_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic keep_ref_q, keep_ref_d;
    logic core_q, core_d;
    logic ref_q, ref_d;
    logic track_q, track_d;
    logic done_n_q, done_n_d;
    logic [BYTE_W-1:0] dout_q, dout_d;
    logic oe_q, oe_d;

    function automatic logic [BYTE_W-1:0] pick_byte(
        input logic [RESULT_W-1:0] word,
        input logic upper
    );
        pick_byte = upper ? word[RESULT_W-1:BYTE_W]
                          : word[BYTE_W-1:0]; // RULE_06 RULE_07
    endfunction : pick_byte

    // stalls in S_STORE while full: a host that skips reads
    // backs up the converter instead of losing results
    assign fifo_in_valid = (state_q == S_STORE);
    assign fifo_out_ready = (state_q == S_READ) && strobe_rise;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        keep_ref_d = keep_ref_q;
        core_d = core_q;
        ref_d = ref_q;
        track_d = track_q;
        result_d = result_q;
        dout_d = dout_q;
        oe_d = oe_q;
        case (state_q)
            S_SHUTDOWN: begin
                if (strobe_fall && !read_convert_select) begin
                    state_d = S_ACQUIRE; // RULE_01
                    core_d = 1'b1;
                    ref_d = 1'b1;
                    track_d = 1'b1;
                end else if (strobe_fall && fifo_out_valid) begin
                    state_d = S_READ; // RULE_05
                    dout_d = pick_byte(fifo_out_data, high_byte_select);
                    oe_d = 1'b1;
                end
            end
            S_ACQUIRE: begin
                if (strobe_fall) begin
                    state_d = S_CONVERT; // RULE_02
                    keep_ref_d = !read_convert_select; // RULE_03
                    track_d = 1'b0;
                    cnt_d = CNT_ZERO;
                end
            end
            S_CONVERT: begin
                if (cnt_q == CONV_LAST) begin
                    state_d = S_STORE;
                    result_d = adc_result;
                end else begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end
            S_STORE: begin
                if (fifo_in_ready) begin
                    state_d = S_SHUTDOWN;
                    core_d = 1'b0;
                    ref_d = keep_ref_q; // RULE_03
                end
            end
            S_READ: begin
                // follows byte select while the strobe is low
                dout_d = pick_byte(fifo_out_data, high_byte_select); // RULE_07
                if (strobe_rise) begin
                    state_d = S_SHUTDOWN;
                    oe_d = 1'b0; // RULE_09
                end
            end
            default: begin
                state_d = S_SHUTDOWN;
                oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= S_SHUTDOWN;
            cnt_q <= CNT_ZERO;
            keep_ref_q <= 1'b0;
            core_q <= 1'b0;
            ref_q <= 1'b0;
            track_q <= 1'b0;
            result_q <= '0;
            dout_q <= '0;
            oe_q <= 1'b0; // RULE_09
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            keep_ref_q <= keep_ref_d;
            core_q <= core_d;
            ref_q <= ref_d;
            track_q <= track_d;
            result_q <= result_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
        end
    end

    // -----------------------------------------------------------------
    // end of conversion
    // -----------------------------------------------------------------
    // own count of buffered results: the line then drops on the push
    // and rises on the last pop, never pulsing between two reads
    logic [CNT_W-1:0] held_q, held_d;

    always_comb begin
        held_d = held_q;
        if (fifo_in_valid && fifo_in_ready) begin
            held_d = held_q + CNT_ONE;
        end else if (fifo_out_ready && fifo_out_valid) begin
            held_d = held_q - CNT_ONE;
        end
        done_n_d = (held_d == CNT_ZERO); // RULE_04
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            held_q <= CNT_ZERO;
            done_n_q <= 1'b1;
        end else begin
            held_q <= held_d;
            done_n_q <= done_n_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign core_power_on = core_q;
    assign ref_power_on = ref_q;
    assign track_enable = track_q;
    assign conversion_done_n = done_n_q;
    assign data_out = dout_q;
    assign data_oe = oe_q;

endmodule : sarps_sequencer

//--- dv/sarps_checker.sv
`timescale 1ns/10ps
module sarps_checker
    import sarps_pkg::*;
#(
    parameter int CONV_COUNT = CONV_CYCLES, parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic conversion_strobe_n,
    input wire logic read_convert_select,
    input wire logic high_byte_select,
    input wire logic core_power_on,
    input wire logic ref_power_on,
    input wire logic track_enable,
    input wire logic conversion_done_n,
    input wire logic [BYTE_W-1:0] data_out,
    input wire logic data_oe
);
    logic stb_q, fall, idle;
    int cnt_q;
    assign fall = stb_q & ~conversion_strobe_n;
    // idle: converter powered down and bus released
    assign idle = ~core_power_on & ~data_oe;
    always_ff @(posedge ref_clk) begin
        stb_q <= reset | conversion_strobe_n;
        cnt_q <= (track_enable & fall) ? 0 : cnt_q + 1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_acq_start: assert property (
        fall && !read_convert_select && idle |=> track_enable && core_power_on)
        else $error("no acquire");
    a_conv_start: assert property (
        track_enable && fall |=> !track_enable) else $error("no convert");
    a_ref_keep: assert property (
        track_enable && fall && !read_convert_select |=> ref_power_on [*8])
        else $error("ref dropped");
    a_ref_off: assert property (
        track_enable && fall && read_convert_select |-> ##[1:600]
        !ref_power_on) else $error("ref kept");
    a_done_time: assert property (
        $fell(conversion_done_n) |-> cnt_q >= CONV_COUNT
        && cnt_q <= CONV_COUNT + 3) else $error("done off time");
    a_read_drive: assert property (
        fall && read_convert_select && idle && !conversion_done_n |=> data_oe)
        else $error("read not driven");
    a_byte_hold: assert property (
        data_oe && $past(data_oe) && $past(high_byte_select) ==
        $past(high_byte_select, 2) |-> $stable(data_out)) else $error("byte");
    a_bus_release: assert property (
        !stb_q && conversion_strobe_n && data_oe |=> !data_oe)
        else $error("bus held");
endmodule : sarps_checker

bind sarps_sequencer sarps_checker #(.CONV_COUNT(CONV_COUNT), .DEPTH(DEPTH))
    u_chk (.ref_clk, .reset, .conversion_strobe_n, .read_convert_select,
    .high_byte_select, .core_power_on, .ref_power_on, .track_enable,
    .conversion_done_n, .data_out, .data_oe);

//--- dv/sarps_host.sv
`timescale 1ns/10ps
module sarps_host
    import sarps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [BYTE_W-1:0] data_in,
    input wire logic data_oe,
    output logic strobe_n,
    output logic select,
    output logic byte_hi
);
    initial {strobe_n, select, byte_hi} = 3'h4;
    task automatic pulse(input logic s);
        @(negedge ref_clk);
        select = s;
        strobe_n = 1'b0;
        @(negedge ref_clk);
        strobe_n = 1'b1;
    endtask : pulse
    task automatic read_word(output logic [15:0] w, output logic oe);
        @(negedge ref_clk);
        select = 1'b1;
        byte_hi = 1'b1;
        strobe_n = 1'b0;
        @(negedge ref_clk);
        oe = data_oe;
        w[15:8] = data_in;
        byte_hi = 1'b0;
        @(negedge ref_clk);
        w[7:0] = data_in;
        strobe_n = 1'b1;
        // settle before any new acquisition
        repeat (4) @(negedge ref_clk);
    endtask : read_word
endmodule : sarps_host

//--- dv/test_sarps_sequencer.sv
`timescale 1ns/10ps
module test_sarps_sequencer
    import sarps_pkg::*;
;
    localparam int CONV = 8;
    logic ref_clk, reset, stb_n, sel, hbs, core, refp, trk, done_n, oe;
    logic [RESULT_W-1:0] adc;
    logic [BYTE_W-1:0] data;
    int err_count = 0, n_checks = 0;
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    sarps_host host (.ref_clk(ref_clk), .data_in(data), .data_oe(oe),
        .strobe_n(stb_n), .select(sel), .byte_hi(hbs));
    sarps_sequencer #(.CONV_COUNT(CONV)) DUT (.ref_clk(ref_clk),
        .reset(reset), .conversion_strobe_n(stb_n), .read_convert_select(sel),
        .high_byte_select(hbs), .adc_result(adc), .core_power_on(core),
        .ref_power_on(refp), .track_enable(trk), .conversion_done_n(done_n),
        .data_out(data), .data_oe(oe));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) $display("mismatch %0t %h %h", $time, seen, exp);
        if (seen !== exp) err_count++;
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    // n results are buffered before any is read back
    task automatic test_stream(input int n, input logic s);
        logic [15:0] w;
        logic got;
        for (int i = 0; i < n; i++) begin
            adc = {i[7:0] ^ 8'h80, ~i[7:0]};
            host.pulse(1'b0);
            check({13'h0, core, refp, trk}, 16'h7);
            host.pulse(s);
            check({15'h0, trk}, 16'h0);
            repeat (CONV + 4) @(negedge ref_clk);
            check({13'h0, refp, core, done_n}, {13'h0, ~s, 2'h0});
        end
        for (int i = 0; i < n; i++) begin
            host.read_word(w, got);
            check(w, {i[7:0] ^ 8'h80, ~i[7:0]});
            check({15'h0, got}, 16'h1);
        end
        check({14'h0, oe, done_n}, 16'h1);
        $display("stream of %0d done", n);
    endtask : test_stream
    initial begin
        reset = 1'b1;
        adc = 16'h0;
        repeat (20) @(negedge ref_clk);
        reset = 1'b0;
        check({11'h0, core, refp, trk, oe, done_n}, 16'h1);
        test_stream(1, 1'b1);
        test_stream(1, 1'b0);
        test_stream(FIFO_DEPTH, 1'b1);
        summarize();
    end
endmodule : test_sarps_sequencer
